// >>> core/tcc_pkg.sv
// ==========================================================================
// Shared constants for the capture/compare timer
package tcc_pkg;

    // ======================================================================
    // Register indices (byte address is four times the index)
    localparam logic [4:0] IDX_STATUS    = 5'h0E;
    localparam logic [4:0] IDX_CNT_HI    = 5'h0F;
    localparam logic [4:0] IDX_CNT_LO    = 5'h10;
    localparam logic [4:0] IDX_MOD_HI    = 5'h11;
    localparam logic [4:0] IDX_MOD_LO    = 5'h12;
    localparam logic [4:0] IDX_CHAN_BASE = 5'h13;
    localparam logic [4:0] CHAN_STRIDE   = 5'h03;
    localparam logic [4:0] CHAN_OFS_CTL  = 5'h00;
    localparam logic [4:0] CHAN_OFS_HI   = 5'h01;
    localparam logic [4:0] CHAN_OFS_LO   = 5'h02;

    // ======================================================================
    // Timer status and control fields
    localparam int ST_TOF    = 7;
    localparam int ST_OVERFLOW_IRQ_ENABLE   = 6;
    localparam int ST_STOP   = 5;
    localparam int ST_RST    = 4;
    localparam int ST_PS_MSB = 2;

    // ======================================================================
    // Channel status and control fields
    localparam int CC_FLAG = 7;
    localparam int CC_IE   = 6;
    localparam int CC_MSB  = 5;
    localparam int CC_MSA  = 4;
    localparam int CC_ELSB = 3;
    localparam int CC_ELSA = 2;
    localparam int CC_TOV  = 1;
    localparam int CC_MAX  = 0;

    // ======================================================================
    // Reset values and counts
    localparam logic [7:0]  STATUS_RST = 8'h20;
    localparam logic [7:0]  CHCTL_RST  = 8'h00;
    localparam logic [15:0] MOD_RST    = 16'hFFFF;
    localparam logic [15:0] CNT_RST    = 16'h0000;
    localparam logic [2:0]  PS_EXT     = 3'h7;
    localparam int          PRE_W      = 6;
    localparam int          NUM_CH     = 4;

    // ======================================================================
    // Channel operating modes
    typedef enum logic [3:0] {
        MODE_OFF = 4'b0001,
        MODE_CAP = 4'b0010,
        MODE_CMP = 4'b0100,
        MODE_BUF = 4'b1000
    } tcc_mode_t;

endpackage

// >>> core/tcc_chan.sv
// ==========================================================================
// One capture/compare channel
module tcc_chan
    import tcc_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        rstn_in,
    input  wire logic        ce_in,
    // Channel setup
    input  wire tcc_mode_t   mode_in,
    input  wire logic [1:0]  els_in,
    input  wire logic        tov_in,
    input  wire logic        max_in,
    // Counter view
    input  wire logic        tick_in,
    input  wire logic        ovf_in,
    input  wire logic [15:0] cnt_in,
    input  wire logic [15:0] cnt_adv_in,
    input  wire logic [15:0] cmp_val_in,
    // Pin
    input  wire logic        pin_in,
    output logic             pin_out,
    output logic             drive_out,
    // Events
    output logic             cap_stb_out,
    output logic [15:0]      cap_val_out,
    output logic             cmp_evt_out
);

    logic        pin_prev_r, pin_prev_nxt;
    logic        cap_d_r, cap_d_nxt;
    logic        lvl_r, lvl_nxt;
    logic [15:0] snap_r, snap_nxt;
    logic        is_cap, is_out, edge_hit;

    // ======================================================================
    // Edge detect, compare and pin level
    always_comb begin
        is_cap = 1'b0;
        is_out = 1'b0;
        case (mode_in)
            MODE_CAP: is_cap = 1'b1;
            MODE_CMP: is_out = 1'b1;
            MODE_BUF: is_out = 1'b1;
            default: is_cap = 1'b0;
        endcase
        edge_hit = is_cap & ((els_in[0] & pin_in & ~pin_prev_r) |
                             (els_in[1] & ~pin_in & pin_prev_r)); // [R7]
        cmp_evt_out = is_out & tick_in & (cnt_adv_in == cmp_val_in); // [R12]
        pin_prev_nxt = pin_in;
        cap_d_nxt = edge_hit;
        snap_nxt = edge_hit ? cnt_in : snap_r; // [R8]
        lvl_nxt = lvl_r;
        if (is_out) begin
            if (ovf_in & tov_in & max_in) begin
                lvl_nxt = ~els_in[0]; // [R25]
            end else begin
                if (ovf_in & tov_in) begin
                    lvl_nxt = ~lvl_r; // [R20]
                end
                if (cmp_evt_out & ~max_in) begin
                    case (els_in)
                        2'b01: lvl_nxt = ~lvl_nxt; // [R12]
                        2'b10: lvl_nxt = 1'b0;
                        2'b11: lvl_nxt = 1'b1;
                        default: lvl_nxt = lvl_nxt;
                    endcase
                end
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            pin_prev_r <= 1'b0;
            cap_d_r    <= 1'b0;
            lvl_r      <= 1'b0;
            snap_r     <= CNT_RST;
        end else if (ce_in) begin
            pin_prev_r <= pin_prev_nxt;
            cap_d_r    <= cap_d_nxt;
            lvl_r      <= lvl_nxt;
            snap_r     <= snap_nxt;
        end
    end

    assign pin_out     = lvl_r;
    assign drive_out   = is_out & (els_in != 2'b00);
    assign cap_stb_out = cap_d_r; // [R9]
    assign cap_val_out = snap_r;

    // ======================================================================
    // Checks
    AST_CAP_DELAY: assert property (@(posedge clk_in) disable iff (!rstn_in) // [R9]
        edge_hit && ce_in |=> cap_stb_out && cap_val_out == $past(cnt_in))
        else $error("capture not presented one cycle after edge");

    AST_CMP_CLEAR: assert property (@(posedge clk_in) disable iff (!rstn_in) // [R12]
        cmp_evt_out && ce_in && !max_in && els_in == 2'b10 |=> !pin_out)
        else $error("clear on compare did not clear pin");

    AST_TOV_TOGGLE: assert property (@(posedge clk_in) disable iff (!rstn_in) // [R20]
        ovf_in && tov_in && !max_in && !cmp_evt_out && is_out && ce_in
        |=> pin_out != $past(pin_out))
        else $error("pin did not toggle on overflow");

    AST_MAX_DUTY: assert property (@(posedge clk_in) disable iff (!rstn_in) // [R25]
        ovf_in && tov_in && max_in && is_out && ce_in |=> pin_out == !$past(els_in[0]))
        else $error("full duty level not forced at overflow");

endmodule

// >>> core/tcc_timer.sv
// ==========================================================================
// Four channel capture/compare timer with Wishbone register access

// Notes on behaviour
// [R1] 16-bit counter, free running or modulo
// [R2] Modulo limit from high and low bytes
// [R3] Counter reads never disturb counting
// [R4] Four channels, each capture or compare
// [R5] 3-bit select: seven rates or external pin
// [R6] Rates divide the bus clock
// [R7] Capture only on selected edge polarity
// [R8] Every active edge captures, flag regardless
// [R9] Captured value stored two cycles later
// [R10] Event sets flag, interrupt when enabled
// [R11] Reset leaves channel values untouched
// [R12] Compare match sets, clears or toggles pin
// [R13] Unbuffered value takes effect at once
// [R14] Software times unbuffered value changes
// [R15] Channel 0 buffer bit links pair 0/1
// [R16] Channel 2 buffer bit links pair 2/3
// [R17] Overflow switches to last written pair
// [R18] Odd channel unused, its pin released
// [R19] Software writes only the inactive pair
// [R20] Toggle on overflow gives PWM period
// [R21] Software picks compare action by polarity
// [R22] Select 0, modulo 255: 256-cycle period
// [R23] Overflow sets flag, interrupt when enabled
// [R24] B mode bit has priority over A
// [R25] No toggle 0 percent; max gives 100
// [R26] Counter wraps to zero after match
module tcc_timer
    import tcc_pkg::*;
(
    // Clock, reset, enable
    input  wire logic        CLK_IN,
    input  wire logic        RSTN_IN,
    input  wire logic        CE_IN,
    // Wishbone slave
    input  wire logic        WB_CYC_IN,
    input  wire logic        WB_STB_IN,
    input  wire logic        WB_WE_IN,
    input  wire logic [31:0] WB_ADR_IN,
    input  wire logic [31:0] WB_DAT_IN,
    input  wire logic [3:0]  WB_SEL_IN,
    output logic      [31:0] WB_DAT_OUT,
    output logic             WB_ACK_OUT,
    // Timer pins
    input  wire logic        EXT_CLK_IN,
    input  wire logic [3:0]  CH_PIN_IN,
    output logic      [3:0]  CH_PIN_OUT,
    output logic      [3:0]  CH_PIN_OE_N_OUT,
    // Interrupt requests
    output logic             OVF_IRQ_OUT,
    output logic      [3:0]  CH_IRQ_OUT
);

    // ======================================================================
    // Declarations
    logic              ack_r, ack_nxt;
    logic [31:0]       dat_r, dat_nxt;
    logic [7:0]        status_r, status_nxt;
    logic [15:0]       mod_r, mod_nxt;
    logic [7:0]        chctl_r [NUM_CH];
    logic [7:0]        chctl_nxt [NUM_CH];
    logic [15:0]       chval_r [NUM_CH];
    logic [15:0]       chval_nxt [NUM_CH];
    logic [1:0]        pair_wr_r, pair_wr_nxt;
    logic [1:0]        pair_act_r, pair_act_nxt;
    logic [15:0]       cnt_r, cnt_nxt, cnt_adv;
    logic [PRE_W-1:0]  pre_r, pre_nxt, pre_mask;
    logic              ext_prev_r, ext_prev_nxt;
    logic              req, wr_en, rst_cmd, tick, ovf;
    logic [4:0]        idx;
    logic [7:0]        rd_byte;
    logic [2:0]        ps;
    logic [1:0]        pair_buf;
    tcc_mode_t         ch_md [NUM_CH];
    logic [15:0]       cmp_val [NUM_CH];
    logic [15:0]       cap_val [NUM_CH];
    logic [NUM_CH-1:0] cap_stb, cmp_evt, ch_drive, ch_lvl;

    function automatic logic [4:0] ch_idx(input int ch, input logic [4:0] ofs);
        return 5'(IDX_CHAN_BASE + CHAN_STRIDE * ch + ofs);
    endfunction

    // B bit wins over A; capture when edges selected
    function automatic tcc_mode_t ch_mode(input logic [7:0] ctl, input logic allow_buf);
        tcc_mode_t m;
        if (allow_buf & ctl[CC_MSB]) begin
            m = MODE_BUF; // [R24]
        end else if (ctl[CC_MSA]) begin
            m = MODE_CMP;
        end else if (ctl[CC_ELSB] | ctl[CC_ELSA]) begin
            m = MODE_CAP;
        end else begin
            m = MODE_OFF;
        end
        return m;
    endfunction

    // ======================================================================
    // Wishbone slave: answer one cycle after request
    assign req     = WB_CYC_IN & WB_STB_IN;
    assign idx     = WB_ADR_IN[6:2];
    assign wr_en   = req & ack_r & WB_WE_IN & WB_SEL_IN[0];
    assign rst_cmd = wr_en & (idx == IDX_STATUS) & WB_DAT_IN[ST_RST];

    always_comb begin
        rd_byte = 8'h00;
        case (idx)
            IDX_STATUS: rd_byte = status_r;
            IDX_CNT_HI: rd_byte = cnt_r[15:8]; // [R3]
            IDX_CNT_LO: rd_byte = cnt_r[7:0];
            IDX_MOD_HI: rd_byte = mod_r[15:8];
            IDX_MOD_LO: rd_byte = mod_r[7:0];
            default: rd_byte = 8'h00;
        endcase
        for (int ch = 0; ch < NUM_CH; ch++) begin
            if (idx == ch_idx(ch, CHAN_OFS_CTL)) begin
                rd_byte = chctl_r[ch];
            end
            if (idx == ch_idx(ch, CHAN_OFS_HI)) begin
                rd_byte = chval_r[ch][15:8];
            end
            if (idx == ch_idx(ch, CHAN_OFS_LO)) begin
                rd_byte = chval_r[ch][7:0];
            end
        end
        ack_nxt = req & ~ack_r;
        dat_nxt = (req & ~ack_r) ? {24'h00_0000, rd_byte} : dat_r;
    end

    always_ff @(posedge CLK_IN) begin
        if (!RSTN_IN) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end else if (CE_IN) begin
            ack_r <= ack_nxt;
            dat_r <= dat_nxt;
        end
    end

    assign WB_ACK_OUT = ack_r;
    assign WB_DAT_OUT = dat_r;

    // ======================================================================
    // Prescaler and counter
    assign ps = status_r[ST_PS_MSB:0];

    always_comb begin
        pre_mask = PRE_W'((7'h01 << ps) - 7'h01); // [R6]
        ext_prev_nxt = EXT_CLK_IN;
        if (ps == PS_EXT) begin
            tick = ~status_r[ST_STOP] & EXT_CLK_IN & ~ext_prev_r; // [R5]
        end else begin
            tick = ~status_r[ST_STOP] & ((pre_r & pre_mask) == pre_mask); // [R5]
        end
        ovf = tick & (cnt_r == mod_r); // [R1]
        cnt_adv = ovf ? CNT_RST : cnt_r + 16'h0001; // [R26]
        if (rst_cmd) begin
            cnt_nxt = CNT_RST;
            pre_nxt = '0;
        end else begin
            cnt_nxt = tick ? cnt_adv : cnt_r;
            pre_nxt = status_r[ST_STOP] ? pre_r : pre_r + PRE_W'(1);
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (!RSTN_IN) begin
            cnt_r      <= CNT_RST;
            pre_r      <= '0;
            ext_prev_r <= 1'b0;
        end else if (CE_IN) begin
            cnt_r      <= cnt_nxt;
            pre_r      <= pre_nxt;
            ext_prev_r <= ext_prev_nxt;
        end
    end

    // ======================================================================
    // Control registers, flags and pair tracking
    always_comb begin
        status_nxt   = status_r;
        mod_nxt      = mod_r;
        pair_wr_nxt  = pair_wr_r;
        pair_act_nxt = pair_act_r;
        for (int ch = 0; ch < NUM_CH; ch++) begin
            chctl_nxt[ch] = chctl_r[ch];
        end
        if (wr_en) begin
            case (idx)
                IDX_STATUS: status_nxt = {status_r[ST_TOF] & WB_DAT_IN[ST_TOF],
                                          WB_DAT_IN[ST_OVERFLOW_IRQ_ENABLE:ST_STOP], 2'b00,
                                          WB_DAT_IN[ST_PS_MSB:0]};
                IDX_MOD_HI: mod_nxt[15:8] = WB_DAT_IN[7:0]; // [R2]
                IDX_MOD_LO: mod_nxt[7:0] = WB_DAT_IN[7:0];
                default: mod_nxt = mod_r;
            endcase
            for (int ch = 0; ch < NUM_CH; ch++) begin
                if (idx == ch_idx(ch, CHAN_OFS_CTL)) begin
                    chctl_nxt[ch] = {chctl_r[ch][CC_FLAG] & WB_DAT_IN[CC_FLAG],
                                     WB_DAT_IN[6:0]};
                    if (ch % 2 == 1) begin
                        chctl_nxt[ch][CC_MSB] = 1'b0;
                    end
                end
                if (idx == ch_idx(ch, CHAN_OFS_HI) || idx == ch_idx(ch, CHAN_OFS_LO)) begin
                    pair_wr_nxt[ch / 2] = (ch % 2 == 1); // [R17]
                end
            end
        end
        status_nxt[ST_TOF] = status_nxt[ST_TOF] | ovf; // [R23]
        for (int ch = 0; ch < NUM_CH; ch++) begin
            chctl_nxt[ch][CC_FLAG] = chctl_nxt[ch][CC_FLAG] | cap_stb[ch] | cmp_evt[ch]; // [R10]
        end
        for (int p = 0; p < 2; p++) begin
            if (!pair_buf[p]) begin
                pair_act_nxt[p] = 1'b0; // [R15] [R16]
            end else if (ovf) begin
                pair_act_nxt[p] = pair_wr_nxt[p]; // [R17]
            end
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (!RSTN_IN) begin
            status_r   <= STATUS_RST;
            mod_r      <= MOD_RST;
            pair_wr_r  <= 2'b00;
            pair_act_r <= 2'b00;
            for (int ch = 0; ch < NUM_CH; ch++) begin
                chctl_r[ch] <= CHCTL_RST;
            end
        end else if (CE_IN) begin
            status_r   <= status_nxt;
            mod_r      <= mod_nxt;
            pair_wr_r  <= pair_wr_nxt;
            pair_act_r <= pair_act_nxt;
            for (int ch = 0; ch < NUM_CH; ch++) begin
                chctl_r[ch] <= chctl_nxt[ch];
            end
        end
    end

    // ======================================================================
    // Channel values: written directly, no reset
    always_comb begin
        for (int ch = 0; ch < NUM_CH; ch++) begin
            chval_nxt[ch] = chval_r[ch];
            if (wr_en && idx == ch_idx(ch, CHAN_OFS_HI)) begin
                chval_nxt[ch][15:8] = WB_DAT_IN[7:0]; // [R13]
            end
            if (wr_en && idx == ch_idx(ch, CHAN_OFS_LO)) begin
                chval_nxt[ch][7:0] = WB_DAT_IN[7:0]; // [R13]
            end
            if (cap_stb[ch]) begin
                chval_nxt[ch] = cap_val[ch]; // [R8]
            end
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (CE_IN) begin
            for (int ch = 0; ch < NUM_CH; ch++) begin
                chval_r[ch] <= chval_nxt[ch]; // [R11]
            end
        end
    end

    // ======================================================================
    // Channel instances
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : gen_ch // [R4]
            if (g % 2 == 0) begin : gen_even
                assign pair_buf[g / 2] = chctl_r[g][CC_MSB]; // [R15] [R16]
                assign ch_md[g] = ch_mode(chctl_r[g], 1'b1);
                assign cmp_val[g] = (pair_buf[g / 2] & pair_act_r[g / 2]) ?
                                    chval_r[g + 1] : chval_r[g]; // [R17]
            end else begin : gen_odd
                assign ch_md[g] = pair_buf[g / 2] ? MODE_OFF
                                                  : ch_mode(chctl_r[g], 1'b0); // [R18]
                assign cmp_val[g] = chval_r[g];
            end
            tcc_chan u_chan (
                .clk_in      (CLK_IN),
                .rstn_in     (RSTN_IN),
                .ce_in       (CE_IN),
                .mode_in     (ch_md[g]),
                .els_in      (chctl_r[g][CC_ELSB:CC_ELSA]),
                .tov_in      (chctl_r[g][CC_TOV]),
                .max_in      (chctl_r[g][CC_MAX]),
                .tick_in     (tick),
                .ovf_in      (ovf),
                .cnt_in      (cnt_r),
                .cnt_adv_in  (cnt_adv),
                .cmp_val_in  (cmp_val[g]),
                .pin_in      (CH_PIN_IN[g]),
                .pin_out     (ch_lvl[g]),
                .drive_out   (ch_drive[g]),
                .cap_stb_out (cap_stb[g]),
                .cap_val_out (cap_val[g]),
                .cmp_evt_out (cmp_evt[g])
            );
            assign CH_PIN_OUT[g]      = ch_lvl[g];
            assign CH_PIN_OE_N_OUT[g] = ~ch_drive[g];
            assign CH_IRQ_OUT[g] = chctl_r[g][CC_FLAG] & chctl_r[g][CC_IE] &
                                   ((g % 2 == 0) | ~pair_buf[g / 2]); // [R10]
        end
    endgenerate

    assign OVF_IRQ_OUT = status_r[ST_TOF] & status_r[ST_OVERFLOW_IRQ_ENABLE]; // [R23]

    // ======================================================================
    // Checks
    AST_WRAP: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN) // [R26]
        CE_IN && tick && cnt_r == mod_r |=> cnt_r == 16'h0000 && status_r[ST_TOF])
        else $error("counter did not wrap with overflow flag");

    AST_COUNT: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN) // [R1]
        CE_IN && tick && cnt_r != mod_r && !rst_cmd |=> cnt_r == $past(cnt_r) + 16'h0001)
        else $error("counter did not advance by one");

    AST_READ_QUIET: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN) // [R3]
        req && !WB_WE_IN && !tick |=> cnt_r == $past(cnt_r))
        else $error("counter changed without a tick during read");

    AST_DIV1: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN) // [R22]
        ps == 3'h0 && !status_r[ST_STOP] |-> tick)
        else $error("undivided rate missed a tick");

    AST_EXT_EDGE: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN) // [R5]
        ps == PS_EXT && tick |-> EXT_CLK_IN && !ext_prev_r)
        else $error("external rate ticked without a rising edge");

    AST_CH_FLAG: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN) // [R10]
        CE_IN && (cmp_evt[0] || cap_stb[0]) |=> chctl_r[0][CC_FLAG])
        else $error("channel event did not set its flag");

    AST_OVF_IRQ: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN) // [R23]
        CE_IN && ovf && status_nxt[ST_OVERFLOW_IRQ_ENABLE] |=> OVF_IRQ_OUT)
        else $error("overflow did not raise its request");

    AST_BUF_SWITCH: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN) // [R17]
        CE_IN && ovf && pair_buf[0] |=> pair_act_r[0] == $past(pair_wr_nxt[0]))
        else $error("buffered pair did not switch to last written");

    AST_ODD_FREE: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN) // [R18]
        pair_buf[1] |-> CH_PIN_OE_N_OUT[3] && !CH_IRQ_OUT[3])
        else $error("odd channel still active in linked pair");

endmodule

// >>> test/tcc_pin_model.sv
// ==========================================================================
// Far side of the channel pins and the external counter clock
module tcc_pin_model (
    // Clock
    input  wire logic       clk_in,
    // Block side
    input  wire logic [3:0] pin_out_in,
    input  wire logic [3:0] oe_n_in,
    // Bench commands
    input  wire logic [3:0] drv_in,
    input  wire logic       ext_en_in,
    // Resolved levels
    output logic      [3:0] pin_in_out,
    output logic            ext_clk_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] div_r = 2'h0;
    // Wire level: block drives when enabled, else the far side
    assign pin_in_out = (~oe_n_in & pin_out_in) | (oe_n_in & drv_in);
    // External clock runs only while asked for, rising every four cycles
    always_ff @(posedge clk_in) begin
        div_r <= ext_en_in ? div_r + 2'h1 : 2'h0;
    end
    assign ext_clk_out = div_r[1];
endmodule

// >>> test/four_channel_capture_compare_timer_tb.sv
// ==========================================================================
// Self-checking bench for the capture/compare timer
module four_channel_capture_compare_timer_tb
    import tcc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin error_cnt++; \
    $display("Error %s exp %h got %h", nm, ex, got); end end
    logic        clk = 1'b0, rstn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [31:0] adr = 32'h0, dat = 32'h0, dout;
    logic [3:0]  sel = 4'hF, drv = 4'h0, pin_in, pin_out, oe_n, ch_irq;
    logic        ack, ext, ext_en = 1'b0, ovf_irq;
    logic [7:0]  q, h;
    logic [15:0] c, r, v;
    int          error_cnt = 0, check_count = 0, cyc_cnt = 0, n, m;
    int          pl[4] = '{0, 1, 2, 7};
    logic [7:0]  acts[3] = '{8'h5C, 8'h58, 8'h54};
    always #20 clk = ~clk;
    tcc_timer u_dut (.CLK_IN(clk), .RSTN_IN(rstn), .CE_IN(1'b1), .WB_CYC_IN(cyc),
        .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_DAT_IN(dat), .WB_SEL_IN(sel),
        .WB_DAT_OUT(dout), .WB_ACK_OUT(ack), .EXT_CLK_IN(ext), .CH_PIN_IN(pin_in),
        .CH_PIN_OUT(pin_out), .CH_PIN_OE_N_OUT(oe_n), .OVF_IRQ_OUT(ovf_irq),
        .CH_IRQ_OUT(ch_irq));
    tcc_pin_model u_pins (.clk_in(clk), .pin_out_in(pin_out), .oe_n_in(oe_n),
        .drv_in(drv), .ext_en_in(ext_en), .pin_in_out(pin_in), .ext_clk_out(ext));
    // ======================================================================
    // Helpers
    function automatic logic [4:0] ci(input int k, input logic [4:0] o);
        return 5'(IDX_CHAN_BASE + CHAN_STRIDE * 5'(k) + o);
    endfunction
    function automatic int hp(input int mo, input int s);
        return (mo + 1) * ((s == 7) ? 4 : (1 << s));
    endfunction
    task automatic bus(input logic w, input logic [4:0] ix, input logic [7:0] d,
                       output logic [7:0] qo);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= {25'h0, ix, 2'h0};
        dat <= {24'h0, d};
        do @(posedge clk); while (ack !== 1'b1);
        qo = dout[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic wr(input logic [4:0] ix, input logic [7:0] d);
        logic [7:0] t;
        bus(1'b1, ix, d, t);
    endtask
    task automatic rd16(input logic [4:0] ix, output logic [15:0] o);
        bus(1'b0, ix, 8'h0, o[15:8]);
        bus(1'b0, 5'(ix + 5'h1), 8'h0, o[7:0]);
    endtask
    task automatic cfg(input int mo, input int s);
        wr(IDX_STATUS, 8'h30);
        wr(IDX_MOD_HI, 8'(mo >> 8));
        wr(IDX_MOD_LO, 8'(mo));
        wr(ci(0, CHAN_OFS_HI), 8'hFF);
        wr(ci(0, CHAN_OFS_LO), 8'hFF);
        wr(ci(0, CHAN_OFS_CTL), 8'h1A);
        ext_en <= (s == 7);
        wr(IDX_STATUS, 8'(s));
    endtask
    task automatic period(output int cnt);
        logic p;
        int k;
        k = 0;
        p = pin_out[0];
        while (pin_out[0] === p && k < 5000) begin @(posedge clk); k++; end
        p = pin_out[0];
        cnt = 0;
        while (pin_out[0] === p && cnt < 5000) begin @(posedge clk); cnt++; end
    endtask
    task automatic test_done();
        $display("Checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc_cnt++;
        if (cyc_cnt == 40000) begin
            error_cnt++;
            test_done();
        end
    end
    // ======================================================================
    // Main sequence
    initial begin
        void'($urandom(32'hdeab));
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        bus(1'b0, IDX_STATUS, 8'h0, q);
        `CHK("status", STATUS_RST, q)
        rd16(IDX_MOD_HI, v);
        `CHK("modulo", MOD_RST, v)
        bus(1'b0, 5'h1F, 8'h0, q);
        `CHK("unmapped", 8'h00, q)
        $display("reset test done");
        for (int i = 0; i < 4; i++) begin
            m = $urandom_range(2, 9);
            cfg(m, pl[i]);
            period(n);
            `CHK("half period", hp(m, pl[i]), n)
        end
        cfg(255, 0);
        period(n);
        `CHK("pwm 256", 256, n)
        bus(1'b0, IDX_CNT_LO, 8'h0, q);
        bus(1'b0, IDX_CNT_LO, 8'h0, h);
        `CHK("count step", 8'h03, 8'(h - q))
        bus(1'b0, IDX_STATUS, 8'h0, q);
        `CHK("ovf flag", 1'b1, q[ST_TOF])
        wr(IDX_STATUS, 8'hE0);
        @(negedge clk);
        `CHK("ovf irq", 1'b1, ovf_irq)
        wr(IDX_STATUS, 8'h60);
        @(negedge clk);
        `CHK("ovf clear", 1'b0, ovf_irq)
        $display("prescale test done");
        wr(IDX_STATUS, 8'h30);
        wr(IDX_MOD_LO, 8'h14);
        wr(ci(2, CHAN_OFS_LO), 8'($urandom_range(1, 19)));
        wr(ci(2, CHAN_OFS_HI), 8'h00);
        wr(IDX_STATUS, 8'h00);
        for (int i = 0; i < 3; i++) begin
            wr(ci(2, CHAN_OFS_CTL), acts[i]);
            n = 0;
            while (pin_out[2] !== !i[0] && n < 200) begin @(posedge clk); n++; end
            `CHK("cmp pin", !i[0], pin_out[2])
        end
        `CHK("cmp drive", 1'b0, oe_n[2])
        `CHK("cmp irq", 1'b1, ch_irq[2])
        $display("compare test done");
        wr(IDX_STATUS, 8'h20);
        rd16(IDX_CNT_HI, c);
        r = 16'($urandom);
        wr(ci(3, CHAN_OFS_HI), r[15:8]);
        wr(ci(3, CHAN_OFS_LO), r[7:0]);
        wr(ci(3, CHAN_OFS_CTL), 8'h48);
        drv[3] <= 1'b1;
        repeat (4) @(posedge clk);
        rd16(ci(3, CHAN_OFS_HI), v);
        `CHK("no capture", r, v)
        drv[3] <= 1'b0;
        repeat (4) @(posedge clk);
        rd16(ci(3, CHAN_OFS_HI), v);
        `CHK("capture", c, v)
        `CHK("cap irq", 1'b1, ch_irq[3])
        wr(ci(3, CHAN_OFS_LO), ~c[7:0]);
        drv[3] <= 1'b1;
        repeat (3) @(posedge clk);
        drv[3] <= 1'b0;
        repeat (4) @(posedge clk);
        rd16(ci(3, CHAN_OFS_HI), v);
        `CHK("recapture", c, v)
        $display("capture test done");
        wr(ci(1, CHAN_OFS_CTL), 8'h1C);
        @(negedge clk);
        `CHK("odd drive", 1'b0, oe_n[1])
        wr(ci(0, CHAN_OFS_CTL), 8'h3A);
        @(negedge clk);
        `CHK("odd released", 1'b1, oe_n[1])
        `CHK("even drive", 1'b0, oe_n[0])
        wr(ci(3, CHAN_OFS_CTL), 8'h1C);
        wr(ci(2, CHAN_OFS_CTL), 8'h2C);
        @(negedge clk);
        `CHK("pair23 odd", 1'b1, oe_n[3])
        wr(ci(1, CHAN_OFS_HI), 8'h00);
        wr(ci(1, CHAN_OFS_LO), 8'($urandom_range(1, 19)));
        wr(IDX_STATUS, 8'h00);
        repeat (60) @(posedge clk);
        bus(1'b0, ci(0, CHAN_OFS_CTL), 8'h0, q);
        `CHK("buffer switch", 1'b1, q[CC_FLAG])
        $display("buffer test done");
        test_done();
    end
endmodule
